/* verilog/gtp_consts.svh */
// register map, field positions, reset values and timing counts of the time-event pin controller
`ifndef GTP_CONSTS_SVH
`define GTP_CONSTS_SVH
`define GTP_OFS_DATA 8'h00
`define GTP_OFS_DIR 8'h04
`define GTP_OFS_BUF 8'h08
`define GTP_OFS_IPOL 8'h0C
`define GTP_OFS_TCFG 8'h10
`define GTP_OFS_IRQ 8'h14
`define GTP_OFS_TIRQ 8'h18
`define GTP_OFS_CAP8_LO 8'h1C
`define GTP_OFS_CAP8_HI 8'h20
`define GTP_OFS_CAP9_LO 8'h24
`define GTP_OFS_CAP9_HI 8'h28
`define GTP_OFS_TGT_LO 8'h2C
`define GTP_OFS_TGT_HI 8'h30
`define GTP_OFS_IND 8'h34
`define GTP_TCFG_OE_LSB 0
`define GTP_TCFG_CLR_LSB 2
`define GTP_TCFG_EPOL_LSB 4
`define GTP_TCFG_MODE_LSB 8
`define GTP_EN_LSB 16
`define GTP_TIRQ_TIMER 0
`define GTP_TIRQ_CAP_LSB 1
`define GTP_RST_PINS 12'h000
`define GTP_RST_TIME 64'h0000_0000_0000_0000
`define GTP_CLK_MHZ 200
`define GTP_FILT_NS 40
`define GTP_FILT_CYC ((`GTP_FILT_NS * `GTP_CLK_MHZ) / 1000)
`define GTP_PULSE_NS 100
`define GTP_PULSE_CYC ((`GTP_PULSE_NS * `GTP_CLK_MHZ) / 1000)
`endif

/* verilog/gtp_pkg.sv */
// types shared by the time-event pin controller
package gtp_pkg;
    typedef logic [11:0] gtp_pins_t;
    typedef enum logic [1:0] {
        GTP_EV_PULSE = 2'h0,
        GTP_EV_TOGGLE = 2'h1,
        GTP_EV_FOLLOW = 2'h2,
        GTP_EV_SPARE = 2'h3
    } gtp_evmode_t;
endpackage : gtp_pkg

/* verilog/gtp_ctrl.sv */
// twelve-pin general io controller with time-event pins, APB register slave
`include "gtp_consts.svh"

module gtp_ctrl
    import gtp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] pin_i,
    output logic [11:0] pin_o,
    output logic [11:0] pin_oe,
    input wire logic [63:0] time_now,
    input wire logic [7:0] indicator_enable_straps,
    input wire logic [3:0] first_port_indicators,
    input wire logic [3:0] second_port_indicators,
    output logic pin_irq,
    output logic time_irq
);

    localparam logic [4:0] FILT_CYC = 5'(`GTP_FILT_CYC);
    localparam logic [4:0] PULSE_CYC = 5'(`GTP_PULSE_CYC);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= `GTP_OFS_IND;
    endfunction : mapped

    gtp_pins_t pin_s_r;
    gtp_pins_t pin_data_bits;
    gtp_pins_t pin_direction_bits;
    gtp_pins_t pin_buffer_type_bits;
    gtp_pins_t pin_irq_polarity_bits;
    gtp_pins_t ists_r;
    gtp_pins_t ists_nxt;
    gtp_pins_t ien_r;
    gtp_pins_t lvl_set;
    gtp_pins_t drv_val;
    gtp_pins_t drv_en;
    logic [1:0] toe_r;
    logic [1:0] tclr_r;
    logic [1:0] epol_r;
    gtp_evmode_t emode_r [2];
    logic [2:0] tsts_r;
    logic [2:0] tsts_nxt;
    logic [2:0] ten_r;
    logic [63:0] cap_r [2];
    logic [63:0] tgt_r;
    logic match_d_r;
    logic tgt_hit;
    logic [7:0] indicator_enable_bits;
    logic strap_done_r;
    logic [1:0] pin_ev;
    logic [1:0] ev_act_r;
    logic [1:0] ev_lvl;
    logic [7:0] ind_n;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    logic wr;
    logic setup;
    logic event_polarity_pin_eight;
    logic event_polarity_pin_nine;
    logic capture_irq_pin_eight;
    logic capture_irq_pin_nine;
    logic smp_ok;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign prdata = prdata_r;
    assign wr = psel & penable & pwrite & mapped(paddr);
    assign setup = psel & ~penable;

    assign event_polarity_pin_eight = epol_r[0];
    assign event_polarity_pin_nine = epol_r[1];
    assign capture_irq_pin_eight = tsts_r[`GTP_TIRQ_CAP_LSB];
    assign capture_irq_pin_nine = tsts_r[`GTP_TIRQ_CAP_LSB + 1];
    assign ind_n = {second_port_indicators, first_port_indicators};
    // first real pin sample lands on the strap capture edge
    assign smp_ok = strap_done_r;

    // pins are synchronous to pclk, one sampling stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s_r <= `GTP_RST_PINS;
        end else begin
            pin_s_r <= pin_i;
        end
    end

    // plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_data_bits <= `GTP_RST_PINS;
            pin_direction_bits <= `GTP_RST_PINS;
            pin_buffer_type_bits <= `GTP_RST_PINS;
            pin_irq_polarity_bits <= `GTP_RST_PINS;
            ien_r <= `GTP_RST_PINS;
            toe_r <= 2'h0;
            tclr_r <= 2'h0;
            epol_r <= 2'h0;
            emode_r[0] <= GTP_EV_PULSE;
            emode_r[1] <= GTP_EV_PULSE;
            ten_r <= 3'h0;
        end else if (wr) begin
            if (hit(paddr, `GTP_OFS_DATA)) begin
                pin_data_bits <= pwdata[11:0];
            end
            if (hit(paddr, `GTP_OFS_DIR)) begin
                pin_direction_bits <= pwdata[11:0];
            end
            if (hit(paddr, `GTP_OFS_BUF)) begin
                pin_buffer_type_bits <= pwdata[11:0];
            end
            if (hit(paddr, `GTP_OFS_IPOL)) begin
                pin_irq_polarity_bits <= pwdata[11:0];
            end
            if (hit(paddr, `GTP_OFS_IRQ)) begin
                ien_r <= pwdata[`GTP_EN_LSB +: 12];
            end
            if (hit(paddr, `GTP_OFS_TIRQ)) begin
                ten_r <= pwdata[`GTP_EN_LSB +: 3];
            end
            if (hit(paddr, `GTP_OFS_TCFG)) begin
                toe_r <= pwdata[`GTP_TCFG_OE_LSB +: 2];
                tclr_r <= pwdata[`GTP_TCFG_CLR_LSB +: 2];
                epol_r <= pwdata[`GTP_TCFG_EPOL_LSB +: 2];
                emode_r[0] <= gtp_evmode_t'(pwdata[`GTP_TCFG_MODE_LSB +: 2]);
                emode_r[1] <= gtp_evmode_t'(pwdata[`GTP_TCFG_MODE_LSB + 2 +: 2]);
            end
        end
    end

    // indicator mode: straps caught on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indicator_enable_bits <= 8'h00;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            indicator_enable_bits <= indicator_enable_straps;
            strap_done_r <= 1'b1;
        end else if (wr && hit(paddr, `GTP_OFS_IND)) begin
            indicator_enable_bits <= pwdata[7:0];
        end
    end

    // compare on the rising edge of equality so a held time value fires once
    assign tgt_hit = (time_now == tgt_r) & ~match_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_r <= `GTP_RST_TIME;
            match_d_r <= 1'b0;
        end else begin
            match_d_r <= time_now == tgt_r;
            if (wr && hit(paddr, `GTP_OFS_TGT_LO)) begin
                tgt_r[31:0] <= pwdata;
            end
            if (wr && hit(paddr, `GTP_OFS_TGT_HI)) begin
                tgt_r[63:32] <= pwdata;
            end
        end
    end

    // per time pin: input filter, capture and event output
    for (genvar g = 0; g < 2; g++) begin : g_tpin
        localparam int P = 8 + g;
        logic [4:0] filt_r;
        logic [4:0] pcnt_r;
        logic is_in;
        logic act;

        assign is_in = ~(pin_direction_bits[P] | toe_r[g]);
        // active level of a time input follows the pin's interrupt polarity
        assign act = smp_ok & (pin_s_r[P] == pin_irq_polarity_bits[P]);
        // fires once, on the sample after 40 ns of steady activity
        assign pin_ev[g] = is_in & act & (filt_r == FILT_CYC);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                filt_r <= 5'h00;
            end else if (!is_in || !act) begin
                filt_r <= 5'h00;
            end else if (filt_r <= FILT_CYC) begin
                filt_r <= filt_r + 5'h01;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_r[g] <= `GTP_RST_TIME;
            end else if (pin_ev[g]) begin
                cap_r[g] <= time_now;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ev_act_r[g] <= 1'b0;
                pcnt_r <= 5'h00;
            end else if (tgt_hit) begin
                unique case (emode_r[g])
                    GTP_EV_TOGGLE: begin
                        ev_act_r[g] <= ~ev_act_r[g];
                    end
                    GTP_EV_FOLLOW: begin
                        ev_act_r[g] <= 1'b0;
                    end
                    GTP_EV_PULSE, GTP_EV_SPARE: begin
                        ev_act_r[g] <= 1'b1;
                        pcnt_r <= PULSE_CYC - 5'h01;
                    end
                endcase
            end else if (emode_r[g] != GTP_EV_TOGGLE && ev_act_r[g]) begin
                // pulse ends after exactly 100 ns
                if (pcnt_r == 5'h00) begin
                    ev_act_r[g] <= 1'b0;
                end else begin
                    pcnt_r <= pcnt_r - 5'h01;
                end
            end
        end

        logic act_now;
        assign act_now = (emode_r[g] == GTP_EV_FOLLOW) ? tsts_r[`GTP_TIRQ_TIMER] : ev_act_r[g];
        assign ev_lvl[g] = epol_r[g] ? act_now : ~act_now;
    end

    // pin interrupt status: level set, write-one clear, set wins
    // the sampler's reset value is not a pin level: without this gate every
    // low-polarity pin would latch a false status on the first edge after reset
    assign lvl_set = ~(pin_s_r ^ pin_irq_polarity_bits) & ~{4'h0, indicator_enable_bits}
        & {12{smp_ok}};

    always_comb begin
        ists_nxt = ists_r;
        if (wr && hit(paddr, `GTP_OFS_IRQ)) begin
            ists_nxt = ists_nxt & ~pwdata[11:0];
        end
        ists_nxt = ists_nxt | lvl_set;
        ists_nxt[9:8] = ists_nxt[9:8] | pin_ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= `GTP_RST_PINS;
        end else begin
            ists_r <= ists_nxt;
        end
    end

    // time unit status: bit 0 target compare, bits 2:1 captures of pins 8, 9
    always_comb begin
        tsts_nxt = tsts_r;
        if (wr && hit(paddr, `GTP_OFS_TIRQ)) begin
            tsts_nxt = tsts_nxt & ~pwdata[2:0];
        end
        if (|(pin_ev & tclr_r)) begin
            tsts_nxt[`GTP_TIRQ_TIMER] = 1'b0;
        end
        if (tgt_hit) begin
            tsts_nxt[`GTP_TIRQ_TIMER] = 1'b1;
        end
        tsts_nxt[`GTP_TIRQ_CAP_LSB +: 2] = tsts_nxt[`GTP_TIRQ_CAP_LSB +: 2] | pin_ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsts_r <= 3'h0;
        end else begin
            tsts_r <= tsts_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_irq <= 1'b0;
            time_irq <= 1'b0;
        end else begin
            pin_irq <= |(ists_r & ien_r);
            time_irq <= |(tsts_r & ten_r);
        end
    end

    // pin drivers
    always_comb begin
        drv_val = pin_data_bits;
        drv_en = pin_direction_bits;
        drv_val[9:8] = {toe_r[1] ? ev_lvl[1] : pin_data_bits[9], toe_r[0] ? ev_lvl[0] : pin_data_bits[8]};
        drv_en[9:8] = pin_direction_bits[9:8] | toe_r;
    end

    for (genvar p = 0; p < 12; p++) begin : g_drv
        logic o_nxt;
        logic oe_nxt;
        always_comb begin
            if (p < 8 && indicator_enable_bits[p % 8]) begin
                o_nxt = 1'b0;
                oe_nxt = ~ind_n[p % 8];
            end else if (!drv_en[p]) begin
                o_nxt = 1'b0;
                oe_nxt = 1'b0;
            end else if (pin_buffer_type_bits[p]) begin
                o_nxt = 1'b0;
                oe_nxt = ~drv_val[p];
            end else begin
                o_nxt = drv_val[p];
                oe_nxt = 1'b1;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_o[p] <= 1'b0;
                pin_oe[p] <= 1'b0;
            end else begin
                pin_o[p] <= o_nxt;
                pin_oe[p] <= oe_nxt;
            end
        end
    end

    // read mux, loaded in the setup cycle
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (paddr)
            `GTP_OFS_DATA: rd_nxt[11:0] = (drv_en & pin_data_bits) | (~drv_en & pin_s_r);
            `GTP_OFS_DIR: rd_nxt[11:0] = pin_direction_bits;
            `GTP_OFS_BUF: rd_nxt[11:0] = pin_buffer_type_bits;
            `GTP_OFS_IPOL: rd_nxt[11:0] = pin_irq_polarity_bits;
            `GTP_OFS_TCFG: begin
                rd_nxt[`GTP_TCFG_OE_LSB +: 2] = toe_r;
                rd_nxt[`GTP_TCFG_CLR_LSB +: 2] = tclr_r;
                rd_nxt[`GTP_TCFG_EPOL_LSB +: 2] = {event_polarity_pin_nine, event_polarity_pin_eight};
                rd_nxt[`GTP_TCFG_MODE_LSB +: 4] = {emode_r[1], emode_r[0]};
            end
            `GTP_OFS_IRQ: begin
                rd_nxt[11:0] = ists_r;
                rd_nxt[`GTP_EN_LSB +: 12] = ien_r;
            end
            `GTP_OFS_TIRQ: begin
                rd_nxt[2:0] = {capture_irq_pin_nine, capture_irq_pin_eight, tsts_r[`GTP_TIRQ_TIMER]};
                rd_nxt[`GTP_EN_LSB +: 3] = ten_r;
            end
            `GTP_OFS_CAP8_LO: rd_nxt = cap_r[0][31:0];
            `GTP_OFS_CAP8_HI: rd_nxt = cap_r[0][63:32];
            `GTP_OFS_CAP9_LO: rd_nxt = cap_r[1][31:0];
            `GTP_OFS_CAP9_HI: rd_nxt = cap_r[1][63:32];
            `GTP_OFS_TGT_LO: rd_nxt = tgt_r[31:0];
            `GTP_OFS_TGT_HI: rd_nxt = tgt_r[63:32];
            `GTP_OFS_IND: rd_nxt[7:0] = indicator_enable_bits;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_r <= rd_nxt;
        end
    end

endmodule : gtp_ctrl

/* tb/gtp_board.sv */
// board side of the pins: external drivers plus pull-up on every pin
module gtp_board (
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_en,
    input wire logic [11:0] ext_val,
    output logic [11:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pins float high, so open-drain data 1 reads back as 1
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule : gtp_board

/* tb/gtp_ctrl_assertions.sv */
// port checker for the time-event pin controller
module gtp_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] pin_i,
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe,
    input wire logic pin_irq,
    input wire logic time_irq
);
    default clocking dcb @(posedge pclk);
    endclocking
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;

    AST_RESET_OUTS: assert property (!presetn |-> pin_oe == 12'h000 && !pin_irq && !time_irq)
        else $error("outputs active during reset");
    AST_READY: assert property (disable iff (!presetn) psel && penable |-> pready)
        else $error("access phase without ready");
    AST_ERR_UNMAPPED: assert property (disable iff (!presetn)
        psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h34) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_ERR_MAPPED: assert property (disable iff (!presetn)
        psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h34 |-> !pslverr)
        else $error("mapped access refused");
    // two-cycle stability covers the input sampling stage
    AST_INPUT_READ: assert property (disable iff (!presetn)
        psel && penable && !pwrite && paddr == 8'h00 && $stable(pin_i) && $past(pin_i) == $past(pin_i, 2)
        |-> ((prdata[11:0] ^ pin_i) & ~pin_oe & ~$past(pin_oe, 2)) == 12'h000)
        else $error("input pin data differs from pin level");
    // pins 11 and 10 have no time or indicator use, so only writes move them
    AST_PINS_QUIET: assert property (disable iff (!presetn)
        $changed({pin_o[11:10], pin_oe[11:10]}) |-> $past(wr_acc, 2))
        else $error("plain pin output moved without a write");
    AST_PRDATA_HOLD: assert property (disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read setup");
    AST_IRQ_CAUSE: assert property (disable iff (!presetn)
        $rose(pin_irq) |-> $past(pin_i, 3) != $past(pin_i, 4) || $past(wr_acc, 2) || $past(wr_acc, 3))
        else $error("pin interrupt rose without cause");
endmodule : gtp_ctrl_chk

bind gtp_ctrl gtp_ctrl_chk u_gtp_ctrl_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_irq(pin_irq), .time_irq(time_irq));

/* tb/tb.sv */
// register-level testbench of the time-event pin controller
`include "gtp_consts.svh"

module tb
    import gtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] pin_i;
    logic [11:0] pin_o;
    logic [11:0] pin_oe;
    logic [63:0] time_now = 64'h0;
    logic [7:0] straps = 8'h01;
    logic [3:0] ind1 = 4'hE;
    logic [3:0] ind2 = 4'hF;
    logic [11:0] ext_en = 12'h000;
    logic [11:0] ext_val = 12'h000;
    logic pin_irq;
    logic time_irq;
    logic [31:0] rd;
    logic l0;
    logic err;
    int fail_count = 0;
    int check_count = 0;
    int n;

    always #2.5 pclk = ~pclk;

    gtp_ctrl u_gtp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .time_now(time_now), .indicator_enable_straps(straps),
        .first_port_indicators(ind1), .second_port_indicators(ind2), .pin_irq(pin_irq), .time_irq(time_irq));
    gtp_board u_gtp_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            t++;
            if (t > 50) begin
                fail_count++;
                end_sim();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // pin 8 held active high for k samples, then released
    task automatic pulse8(input int k);
        ext_val <= ext_val | 12'h100;
        cyc(k);
        ext_val <= ext_val & 12'hEFF;
        cyc(4);
    endtask : pulse8

    // equality rises, then 40 cycles of the chosen event output are counted
    task automatic fire(input logic use_oe);
        time_now <= 64'h1_0000_00FF;
        cyc(2);
        time_now <= 64'h1_0000_0100;
        n = 0;
        repeat (40) begin
            @(posedge pclk);
            n += int'(use_oe ? pin_oe[9] === 1'b1 : pin_o[9] === 1'b1);
        end
    endtask : fire

    initial begin
        presetn <= 1'b0;
        cyc(12);
        presetn <= 1'b1;
        cyc(3);
        chk({8'h0, pin_oe, pin_o}, {8'h0, 12'h001, 12'h000});
        rdc(`GTP_OFS_DIR, 32'h0);
        rdc(`GTP_OFS_IRQ, 32'h0);
        rdc(`GTP_OFS_IPOL, 32'h0);
        rdc(`GTP_OFS_IND, 32'h1);
        ind1 <= 4'hF;
        cyc(3);
        chk({20'h0, pin_oe}, 32'h0);
        wr(`GTP_OFS_IND, 32'h0);
        rdc(8'h38, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(8'h06, 32'hFFF);
        chk({31'h0, err}, 32'h1);
        rdc(`GTP_OFS_DIR, 32'h0);
        chk({31'h0, err}, 32'h0);
        $display("test reset done");
        wr(`GTP_OFS_DATA, 32'h400);
        wr(`GTP_OFS_DIR, 32'hC00);
        cyc(3);
        chk({8'h0, pin_oe, pin_o}, {8'h0, 12'hC00, 12'h400});
        wr(`GTP_OFS_BUF, 32'h800);
        cyc(3);
        chk({8'h0, pin_oe, pin_o}, {8'h0, 12'hC00, 12'h400});
        wr(`GTP_OFS_DATA, 32'hC00);
        cyc(3);
        chk({8'h0, pin_oe, pin_o}, {8'h0, 12'h400, 12'h400});
        rdc(`GTP_OFS_DATA, 32'hFFF);
        wr(`GTP_OFS_DIR, 32'h0);
        wr(`GTP_OFS_BUF, 32'h0);
        ext_en <= 12'hFFF;
        ext_val <= 12'hA5A;
        cyc(3);
        rdc(`GTP_OFS_DATA, 32'hA5A);
        $display("test pins done");
        ext_val <= 12'hFFF;
        cyc(3);
        wr(`GTP_OFS_IRQ, 32'hFFF);
        rdc(`GTP_OFS_IRQ, 32'h0);
        wr(`GTP_OFS_IRQ, 32'h20000);
        ext_val <= 12'hFFD;
        cyc(4);
        rdc(`GTP_OFS_IRQ, 32'h20002);
        chk({31'h0, pin_irq}, 32'h1);
        wr(`GTP_OFS_IRQ, 32'h20002);
        rdc(`GTP_OFS_IRQ, 32'h20002);
        wr(`GTP_OFS_IPOL, 32'h002);
        wr(`GTP_OFS_IRQ, 32'h20002);
        cyc(3);
        rdc(`GTP_OFS_IRQ, 32'h20000);
        chk({31'h0, pin_irq}, 32'h0);
        ext_val <= 12'hFFF;
        cyc(4);
        rdc(`GTP_OFS_IRQ, 32'h20002);
        wr(`GTP_OFS_IRQ, 32'h0);
        cyc(3);
        chk({31'h0, pin_irq}, 32'h0);
        $display("test interrupts done");
        wr(`GTP_OFS_IPOL, 32'h100);
        ext_val <= 12'hEFF;
        time_now <= 64'h1234_5678_9ABC_DEF0;
        cyc(3);
        wr(`GTP_OFS_IRQ, 32'hFFF);
        wr(`GTP_OFS_TIRQ, 32'h7);
        // 8 samples is exactly 40 ns, too short to count
        pulse8(8);
        rdc(`GTP_OFS_TIRQ, 32'h0);
        pulse8(12);
        rdc(`GTP_OFS_TIRQ, 32'h2);
        rdc(`GTP_OFS_CAP8_LO, 32'h9ABC_DEF0);
        rdc(`GTP_OFS_CAP8_HI, 32'h1234_5678);
        rdc(`GTP_OFS_IRQ, 32'h100);
        chk({31'h0, time_irq}, 32'h0);
        wr(`GTP_OFS_TIRQ, 32'h20000);
        cyc(3);
        chk({31'h0, time_irq}, 32'h1);
        wr(`GTP_OFS_TIRQ, 32'h2);
        $display("test capture done");
        wr(`GTP_OFS_TGT_LO, 32'h100);
        wr(`GTP_OFS_TGT_HI, 32'h1);
        fire(1'b0);
        rdc(`GTP_OFS_TIRQ, 32'h1);
        wr(`GTP_OFS_TCFG, 32'h4);
        pulse8(12);
        rdc(`GTP_OFS_TIRQ, 32'h2);
        wr(`GTP_OFS_TIRQ, 32'h7);
        wr(`GTP_OFS_TCFG, 32'h22 | (32'(GTP_EV_PULSE) << 10));
        fire(1'b0);
        chk(n, `GTP_PULSE_CYC);
        chk({31'h0, pin_oe[9]}, 32'h1);
        wr(`GTP_OFS_TIRQ, 32'h1);
        wr(`GTP_OFS_TCFG, 32'h22 | (32'(GTP_EV_FOLLOW) << 10));
        fire(1'b0);
        chk({31'h0, pin_o[9]}, 32'h1);
        wr(`GTP_OFS_TIRQ, 32'h1);
        cyc(3);
        chk({31'h0, pin_o[9]}, 32'h0);
        wr(`GTP_OFS_TCFG, 32'h22 | (32'(GTP_EV_TOGGLE) << 10));
        cyc(3);
        l0 = pin_o[9];
        fire(1'b0);
        chk({31'h0, pin_o[9]}, {31'h0, ~l0});
        fire(1'b0);
        chk({31'h0, pin_o[9]}, {31'h0, l0});
        // active low on open drain: the low pulse is the only time the pin is driven
        wr(`GTP_OFS_BUF, 32'h200);
        wr(`GTP_OFS_TCFG, 32'h02 | (32'(GTP_EV_SPARE) << 10));
        cyc(3);
        fire(1'b1);
        chk(n, `GTP_PULSE_CYC);
        $display("test events done");
        // mid-run reset must undo direction, enables and polarity
        wr(`GTP_OFS_DIR, 32'hFFF);
        wr(`GTP_OFS_IRQ, 32'h0FFF_0000);
        presetn <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
        cyc(3);
        chk({20'h0, pin_oe}, 32'h0);
        rdc(`GTP_OFS_DIR, 32'h0);
        rdc(`GTP_OFS_IPOL, 32'h0);
        rdc(`GTP_OFS_IRQ, 32'h100);
        $display("test mid reset done");
        end_sim();
    end
endmodule : tb
